// File: verilog/sfr_regs.svh
// opcodes, field values and timing figures for the serial flash sequencer
// assumes inclusion by the sequencer module
`ifndef SFR_REGS_SVH
`define SFR_REGS_SVH
// ****************************************
// opcodes
// ****************************************
`define SFR_OP_READ 8'h03
`define SFR_OP_FAST 8'h0B
`define SFR_OP_DUAL 8'h3B
`define SFR_OP_QUAD 8'h6B
`define SFR_OP_CE_A 8'hC7
`define SFR_OP_CE_B 8'h60
`define SFR_OP_SE 8'h20
`define SFR_OP_BE32 8'h52
`define SFR_OP_BE64 8'hD8
`define SFR_OP_SRER 8'h44
`define SFR_OP_PP 8'h02
`define SFR_OP_QPP 8'h32
`define SFR_OP_SRPP 8'h42
`define SFR_OP_SUSP 8'h75
`define SFR_OP_RESUME 8'h7A
`define SFR_OP_WREN 8'h06
`define SFR_OP_WRDI 8'h04
// ****************************************
// fields and counts
// ****************************************
`define SFR_ERASED 8'hFF
`define SFR_SPI_OP_CLK 6'h08
`define SFR_QPI_OP_CLK 6'h02
`define SFR_SPI_ADR_CLK 6'h18
`define SFR_QPI_ADR_CLK 6'h06
`define SFR_SPI_DUMMY 6'h08
`define SFR_RDP_RESET 2'h0
`define SFR_SEC_HI 23
`define SFR_SEC_LO 12
// ****************************************
// timing
// ****************************************
`define SFR_CLK_MHZ 200
`define SFR_T_OP_NS 100000
`define SFR_T_SUS_NS 20000
`endif

// File: verilog/sfr_pkg.sv
// types shared by the serial flash sequencer
// assumes nothing of its surroundings
package sfr_pkg;
  typedef enum logic [2:0] {
    SFR_IDLE = 3'h0,
    SFR_CHIP = 3'h1,
    SFR_BGOP = 3'h2,
    SFR_SUSPENDING = 3'h3,
    SFR_SUSPENDED = 3'h4,
    SFR_NEST = 3'h5
  } sfr_state_t;
endpackage

// File: verilog/sfr_flash.sv
// serial NOR flash command sequencer: erase, suspend/resume and read paths
// assumes sclk_in is the host's serial clock, stopped outside frames,
// and that status/config levels arrive as plain ports
`include "sfr_regs.svh"

// How it works
// - with write enable latched, a lone C7h or 60h erases every byte to FFh.
// - the whole-array erase runs only when the frame holds exactly eight bits.
// - busy stays 1 through the erase and drops to 0 at completion.
// - completing the whole-array erase clears the write enable latch.
// - any set protect field bit blocks the whole-array erase.
// - suspend 75h is taken only when not suspended and a sector/program op runs.
// - an erase suspension blocks every erase opcode.
// - a program suspension blocks every program opcode.
// - suspend during whole-array erase is ignored.
// - while suspended, program or erase on the suspended sector is ignored.
// - accepted suspend sets the suspended flag at once; busy drops within latency.
// - resume 7Ah only when suspended and idle; flag clears, busy rises at once.
// - read 03h plus 24-bit address in on rising edges, data out MSB first.
// - read address increments per byte until chip select rises.
// - reads issued while busy are ignored and leave the running cycle alone.
// - single-line fast read 0Bh waits eight don't-care dummy clocks.
// - quad command mode dummy count follows read parameter: 4,4,6,8; resets to 4.
// - dual read 3Bh waits eight dummy clocks then drives two bits per clock.
// - quad read 6Bh needs quad enable, then drives four bits per clock.
module sfr_flash #(
  parameter int AW = 20,
  parameter int T_OP_NS = `SFR_T_OP_NS,
  parameter int T_SUS_NS = `SFR_T_SUS_NS
) (
  input wire logic clock_in, // core clock
  input wire logic reset_in, // reset, active high; synchronous in the core, asynchronous on the link side
  input wire logic sclk_in, // serial link clock
  input wire logic chip_select_n_in, // frame select, active low
  input wire logic io_line_0_in, // line 0 level
  input wire logic io_line_1_in, // line 1 level
  input wire logic io_line_2_in, // line 2 level
  input wire logic io_line_3_in, // line 3 level
  output logic io_line_0_out, // line 0 drive value
  output logic io_line_1_out, // line 1 drive value
  output logic io_line_2_out, // line 2 drive value
  output logic io_line_3_out, // line 3 drive value
  output logic io_line_0_oe_n_out, // line 0 drive enable, active low
  output logic io_line_1_oe_n_out, // line 1 drive enable, active low
  output logic io_line_2_oe_n_out, // line 2 drive enable, active low
  output logic io_line_3_oe_n_out, // line 3 drive enable, active low
  input wire logic quad_lines_enable_in, // allows quad data read
  input wire logic quad_command_mode_in, // four-line command mode
  input wire logic protect_field_bit2_in, // block protect field
  input wire logic protect_field_bit1_in, // block protect field
  input wire logic protect_field_bit0_in, // block protect field
  input wire logic [1:0] read_param_in, // dummy count code
  input wire logic read_param_load_in, // loads read_param_in
  output logic busy_out, // operation in progress
  output logic write_enable_latch_out, // write enable latch
  output logic suspended_flag_out // operation suspended
);

  localparam logic [31:0] OP_CYC = 32'((T_OP_NS * `SFR_CLK_MHZ + 999) / 1000);
  localparam int SUS_RAW = (T_SUS_NS * `SFR_CLK_MHZ) / 1000;
  localparam logic [31:0] SUS_CYC = 32'((SUS_RAW < 1) ? 1 : SUS_RAW);

  function automatic logic [5:0] op_clks(input logic q);
    op_clks = q ? `SFR_QPI_OP_CLK : `SFR_SPI_OP_CLK;
  endfunction

  function automatic logic [5:0] adr_clks(input logic q);
    adr_clks = q ? `SFR_QPI_ADR_CLK : `SFR_SPI_ADR_CLK;
  endfunction

  function automatic logic [5:0] dummy_clks(input logic q, input logic [1:0] p);
    if (!q) begin
      dummy_clks = `SFR_SPI_DUMMY;
    end else begin
      case (p)
        2'h2: dummy_clks = 6'h06;
        2'h3: dummy_clks = 6'h08;
        default: dummy_clks = 6'h04;
      endcase
    end
  endfunction

  logic [7:0] mem [0:(1 << AW) - 1];

  // ****************************************
  // link side: command capture on rising edges
  // ****************************************
  logic fresh_r;
  logic [5:0] lcnt_r;
  logic [7:0] op_r;
  logic [23:0] addr_r;
  logic tgl_r;
  logic qpi_r;
  logic [4:0] lsync1_r;
  logic [4:0] lsync2_r;
  logic [1:0] rdp_r;
  logic busy_r;

  wire logic busy_l = lsync2_r[4];
  wire logic qe_l = lsync2_r[3];
  wire logic [1:0] rdp_l = lsync2_r[1:0];
  wire logic [3:0] in4 = {io_line_3_in, io_line_2_in, io_line_1_in, io_line_0_in};
  wire logic qpi_nxt = fresh_r ? lsync2_r[2] : qpi_r;
  wire logic [5:0] lcnt_nxt = fresh_r ? 6'h01 : (lcnt_r == 6'h3F) ? lcnt_r : lcnt_r + 6'h01;
  wire logic in_op = lcnt_nxt <= op_clks(qpi_nxt);
  wire logic in_adr = !in_op && (lcnt_nxt <= op_clks(qpi_nxt) + adr_clks(qpi_nxt));
  wire logic [7:0] op_nxt = qpi_nxt ? {op_r[3:0], in4} : {op_r[6:0], io_line_0_in};
  wire logic [23:0] adr_nxt = qpi_nxt ? {addr_r[19:0], in4} : {addr_r[22:0], io_line_0_in};

  always_ff @(posedge sclk_in or posedge chip_select_n_in) begin
    if (chip_select_n_in) begin
      fresh_r <= 1'h1;
    end else begin
      fresh_r <= 1'h0;
    end
  end

  // status syncs share the link reset so the first frame never sees unknown mode or busy
  always_ff @(posedge sclk_in or posedge reset_in) begin
    if (reset_in) begin
      lsync1_r <= 5'h00;
      lsync2_r <= 5'h00;
      lcnt_r <= 6'h00;
      op_r <= 8'h00;
      addr_r <= 24'h000000;
      tgl_r <= 1'h0;
      qpi_r <= 1'h0;
    end else begin
      lsync1_r <= {busy_r, quad_lines_enable_in, quad_command_mode_in, rdp_r};
      lsync2_r <= lsync1_r;
      lcnt_r <= lcnt_nxt;
      qpi_r <= qpi_nxt;
      op_r <= in_op ? op_nxt : op_r;
      addr_r <= in_adr ? adr_nxt : addr_r;
      tgl_r <= tgl_r ^ (lcnt_nxt == op_clks(qpi_nxt));
    end
  end

  // ****************************************
  // link side: read data on falling edges
  // ****************************************
  logic [3:0] io_o_r;
  logic [3:0] oe_n_r;
  logic [2:0] pos_r;
  logic [7:0] sh_r;
  logic run_r;
  logic [AW-1:0] ra_r;

  wire logic rd03 = (op_r == `SFR_OP_READ) && !qpi_r;
  wire logic rd0b = op_r == `SFR_OP_FAST;
  wire logic rd3b = (op_r == `SFR_OP_DUAL) && !qpi_r;
  wire logic rd6b = (op_r == `SFR_OP_QUAD) && !qpi_r && qe_l;
  wire logic rd_ok = (rd03 || rd0b || rd3b || rd6b) && !busy_l;
  wire logic [2:0] lanes = (qpi_r || rd6b) ? 3'h4 : rd3b ? 3'h2 : 3'h1;
  wire logic [5:0] dum = rd03 ? 6'h00 : dummy_clks(qpi_r, rdp_l);
  wire logic [5:0] start = op_clks(qpi_r) + adr_clks(qpi_r) + dum;
  wire logic dat_go = rd_ok && (lcnt_r >= start);
  wire logic [AW-1:0] cur_a = run_r ? ra_r : addr_r[AW-1:0];
  wire logic [7:0] nsh = (pos_r == 3'h0) ? mem[cur_a] : sh_r;
  wire logic [3:0] io_nxt = (lanes == 3'h4) ? nsh[7:4] :
                            (lanes == 3'h2) ? {2'h0, nsh[7:6]} : {2'h0, nsh[7], 1'h0};
  wire logic [3:0] oe_nxt = (lanes == 3'h4) ? 4'h0 : (lanes == 3'h2) ? 4'hC : 4'hD;
  wire logic [7:0] sh_nxt = (lanes == 3'h4) ? {nsh[3:0], 4'h0} :
                            (lanes == 3'h2) ? {nsh[5:0], 2'h0} : {nsh[6:0], 1'h0};

  always_ff @(negedge sclk_in or posedge chip_select_n_in) begin
    if (chip_select_n_in) begin
      io_o_r <= 4'h0;
      oe_n_r <= 4'hF;
      pos_r <= 3'h0;
      sh_r <= 8'h00;
      run_r <= 1'h0;
      ra_r <= '0;
    end else if (dat_go) begin
      io_o_r <= io_nxt;
      oe_n_r <= oe_nxt;
      pos_r <= pos_r + lanes;
      sh_r <= sh_nxt;
      run_r <= 1'h1;
      ra_r <= (pos_r == 3'h0) ? cur_a + 1'h1 : ra_r;
    end
  end

  assign {io_line_3_out, io_line_2_out, io_line_1_out, io_line_0_out} = io_o_r;
  assign io_line_0_oe_n_out = oe_n_r[0];
  assign io_line_1_oe_n_out = oe_n_r[1];
  assign io_line_2_oe_n_out = oe_n_r[2];
  assign io_line_3_oe_n_out = oe_n_r[3];

  // ****************************************
  // core side: frame end detection
  // ****************************************
  logic [2:0] cs_s_r;
  logic [1:0] tg_s_r;
  logic seen_r;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      cs_s_r <= 3'h7;
      tg_s_r <= 2'h0;
      seen_r <= 1'h0;
    end else begin
      cs_s_r <= {cs_s_r[1:0], chip_select_n_in};
      tg_s_r <= {tg_s_r[0], tgl_r};
      seen_r <= (cs_s_r[1] && !cs_s_r[2]) ? tg_s_r[1] : seen_r;
    end
  end

  // op, count and address are frozen once the link clock stops
  wire logic frame_end = cs_s_r[1] && !cs_s_r[2] && (tg_s_r[1] != seen_r);
  wire logic [5:0] oc = op_clks(qpi_r);
  wire logic [5:0] ac = oc + adr_clks(qpi_r);
  wire logic exact = lcnt_r == oc;
  wire logic [11:0] tsec = addr_r[`SFR_SEC_HI:`SFR_SEC_LO];
  wire logic is_ce = exact && (op_r == `SFR_OP_CE_A || op_r == `SFR_OP_CE_B);
  wire logic is_er = (lcnt_r == ac) && (op_r == `SFR_OP_SE || op_r == `SFR_OP_BE32 ||
                     op_r == `SFR_OP_BE64 || op_r == `SFR_OP_SRER);
  wire logic is_pg = (lcnt_r > ac) && (op_r == `SFR_OP_PP || op_r == `SFR_OP_QPP ||
                     op_r == `SFR_OP_SRPP);
  wire logic is_sus = exact && op_r == `SFR_OP_SUSP;
  wire logic is_res = exact && op_r == `SFR_OP_RESUME;
  wire logic is_wren = exact && op_r == `SFR_OP_WREN;
  wire logic is_wrdi = exact && op_r == `SFR_OP_WRDI;

  // ****************************************
  // core side: operation sequencer
  // ****************************************
  sfr_pkg::sfr_state_t st_r;
  sfr_pkg::sfr_state_t st_nxt;
  logic [31:0] ctr_r;
  logic [31:0] ctr_nxt;
  logic [31:0] sav_r;
  logic [31:0] sav_nxt;
  logic wel_r;
  logic wel_nxt;
  logic sus_r;
  logic sus_nxt;
  logic kind_pg_r;
  logic kind_pg_nxt;
  logic [11:0] sec_r;
  logic [11:0] sec_nxt;
  logic [AW-1:0] ea_r;
  logic [AW-1:0] ea_nxt;

  wire logic busy_now = st_r != sfr_pkg::SFR_IDLE && st_r != sfr_pkg::SFR_SUSPENDED;
  wire logic prot = protect_field_bit2_in || protect_field_bit1_in || protect_field_bit0_in;
  wire logic blocked = sus_r && ((kind_pg_r ? is_pg : is_er) || tsec == sec_r);
  wire logic ce_go = frame_end && is_ce && wel_r && !busy_now && !sus_r && !prot;
  wire logic bg_go = frame_end && (is_er || is_pg) && wel_r && !busy_now && !blocked;
  wire logic sus_go = frame_end && is_sus && !sus_r && st_r == sfr_pkg::SFR_BGOP;
  wire logic res_go = frame_end && is_res && st_r == sfr_pkg::SFR_SUSPENDED;
  wire logic busy_nxt = st_nxt != sfr_pkg::SFR_IDLE && st_nxt != sfr_pkg::SFR_SUSPENDED;
  wire logic ea_last = ea_r == {AW{1'h1}};

  always_comb begin
    st_nxt = st_r;
    ctr_nxt = (ctr_r == 32'h0) ? ctr_r : ctr_r - 32'h1;
    sav_nxt = sav_r;
    wel_nxt = wel_r;
    sus_nxt = sus_r;
    kind_pg_nxt = kind_pg_r;
    sec_nxt = sec_r;
    ea_nxt = ea_r;
    case (st_r)
      sfr_pkg::SFR_IDLE: begin
      end
      sfr_pkg::SFR_CHIP: begin
        ea_nxt = ea_r + 1'h1;
        if (ea_last) begin
          st_nxt = sfr_pkg::SFR_IDLE;
          wel_nxt = 1'h0;
        end
      end
      sfr_pkg::SFR_BGOP: begin
        if (ctr_r == 32'h0) begin
          st_nxt = sfr_pkg::SFR_IDLE;
          wel_nxt = 1'h0;
        end
      end
      sfr_pkg::SFR_SUSPENDING: begin
        if (ctr_r == 32'h0) begin
          st_nxt = sfr_pkg::SFR_SUSPENDED;
        end
      end
      sfr_pkg::SFR_SUSPENDED: begin
      end
      sfr_pkg::SFR_NEST: begin
        if (ctr_r == 32'h0) begin
          st_nxt = sfr_pkg::SFR_SUSPENDED;
          wel_nxt = 1'h0;
        end
      end
      default: begin
        st_nxt = sfr_pkg::SFR_IDLE;
      end
    endcase
    if (frame_end && is_wren) begin
      wel_nxt = 1'h1;
    end
    if (frame_end && is_wrdi) begin
      wel_nxt = 1'h0;
    end
    if (ce_go) begin
      st_nxt = sfr_pkg::SFR_CHIP;
      ea_nxt = '0;
    end
    if (bg_go) begin
      st_nxt = sus_r ? sfr_pkg::SFR_NEST : sfr_pkg::SFR_BGOP;
      ctr_nxt = OP_CYC;
      if (!sus_r) begin
        kind_pg_nxt = is_pg;
        sec_nxt = tsec;
      end
    end
    if (sus_go) begin
      st_nxt = sfr_pkg::SFR_SUSPENDING;
      sav_nxt = ctr_r;
      ctr_nxt = SUS_CYC - 32'h1;
      sus_nxt = 1'h1;
    end
    if (res_go) begin
      st_nxt = sfr_pkg::SFR_BGOP;
      ctr_nxt = sav_r;
      sus_nxt = 1'h0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      st_r <= sfr_pkg::SFR_IDLE;
      ctr_r <= 32'h0;
      sav_r <= 32'h0;
      wel_r <= 1'h0;
      sus_r <= 1'h0;
      kind_pg_r <= 1'h0;
      sec_r <= 12'h000;
      ea_r <= '0;
      busy_r <= 1'h0;
      rdp_r <= `SFR_RDP_RESET;
    end else begin
      st_r <= st_nxt;
      ctr_r <= ctr_nxt;
      sav_r <= sav_nxt;
      wel_r <= wel_nxt;
      sus_r <= sus_nxt;
      kind_pg_r <= kind_pg_nxt;
      sec_r <= sec_nxt;
      ea_r <= ea_nxt;
      busy_r <= busy_nxt;
      rdp_r <= read_param_load_in ? read_param_in : rdp_r;
    end
  end

  always_ff @(posedge clock_in) begin
    if (st_r == sfr_pkg::SFR_CHIP) begin
      mem[ea_r] <= `SFR_ERASED;
    end
  end

  assign busy_out = busy_r;
  assign write_enable_latch_out = wel_r;
  assign suspended_flag_out = sus_r;

endmodule // sfr_flash

// File: test/sfr_flash_assertions.sv
// checker for status flags and line release of the flash sequencer
// assumes binding to sfr_flash with a matching suspend latency
module sfr_flash_assertions #(
  parameter int T_SUS_NS = 20
) (
  input wire logic clock_in, // core clock
  input wire logic reset_in, // reset, active high
  input wire logic sclk_in, // link clock
  input wire logic chip_select_n_in, // frame select
  input wire logic io_line_0_oe_n_out, // line 0 enable
  input wire logic io_line_1_oe_n_out, // line 1 enable
  input wire logic io_line_3_oe_n_out, // line 3 enable
  input wire logic quad_lines_enable_in, // quad enable
  input wire logic quad_command_mode_in, // quad command mode
  input wire logic busy_out, // busy flag
  input wire logic write_enable_latch_out, // write enable latch
  input wire logic suspended_flag_out // suspended flag
);
  localparam int SUS_MAX = T_SUS_NS * 200 / 1000 + 3;
  // ****************************************
  // core domain
  // ****************************************
  chk_sus_entry: assert property (@(posedge clock_in) disable iff (reset_in)
    $rose(suspended_flag_out) |-> busy_out && $past(busy_out)) else $error("suspend while idle");
  chk_sus_busy_drop: assert property (@(posedge clock_in) disable iff (reset_in)
    $rose(suspended_flag_out) |-> ##[0:SUS_MAX] !busy_out) else $error("busy held too long");
  chk_resume_busy: assert property (@(posedge clock_in) disable iff (reset_in)
    $fell(suspended_flag_out) |-> busy_out && !$past(busy_out)) else $error("bad resume");
  chk_wel_clear: assert property (@(posedge clock_in) disable iff (reset_in)
    $fell(busy_out) && !suspended_flag_out |-> !write_enable_latch_out)
    else $error("latch kept after cycle");
  chk_busy_cause: assert property (@(posedge clock_in) disable iff (reset_in)
    $rose(busy_out) |-> $past(chip_select_n_in, 2)) else $error("busy inside a frame");
  chk_idle_release: assert property (@(posedge clock_in) disable iff (reset_in)
    chip_select_n_in && $past(chip_select_n_in)
    |-> io_line_0_oe_n_out && io_line_1_oe_n_out && io_line_3_oe_n_out)
    else $error("line driven while deselected");
  // ****************************************
  // link domain
  // ****************************************
  chk_busy_read: assert property (@(posedge sclk_in) disable iff (reset_in)
    !chip_select_n_in && busy_out && $past(busy_out, 4)
    |-> io_line_0_oe_n_out && io_line_1_oe_n_out) else $error("read served while busy");
  chk_quad_gate: assert property (@(posedge sclk_in) disable iff (reset_in)
    !quad_lines_enable_in && !quad_command_mode_in |-> io_line_3_oe_n_out)
    else $error("line 3 driven without quad enable");
endmodule // sfr_flash_assertions

// File: test/sfr_host_model.sv
// host side of the serial link: clocks frames and resolves the shared lines
// assumes the device releases its lines through active-low enables
module sfr_host_model (
  input wire logic [3:0] dev_val_in, // device drive values io3..io0
  input wire logic [3:0] dev_oe_n_in, // device enables, active low
  output logic sclk_out, // link clock, low between frames
  output logic cs_n_out, // frame select, active low
  output logic [3:0] line_out // resolved levels io3..io0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic hdrv = 1'b0;
  logic flip = 1'b0;
  logic [3:0] hval = 4'h0;
  initial sclk_out = 1'b0;
  // a power-up edge on select clears the device's link output stage
  initial begin
    cs_n_out = 1'b0;
    #1 cs_n_out = 1'b1;
  end
  // undriven lines toggle so a stale level never reads as data
  always @(negedge sclk_out) flip <= ~flip;
  assign line_out = (~dev_oe_n_in & dev_val_in) | (dev_oe_n_in & (hdrv ? hval : {4{flip}}));
  // tx is left aligned; ok drops on early drive or on an undriven data lane
  task automatic frame(input logic [63:0] tx, input int ntx, input int wtx, input int nrx,
                       input int wrx, output logic [31:0] rx, output logic ok);
    logic [3:0] need;
    need = (wrx == 1) ? 4'h2 : (wrx == 2) ? 4'h3 : 4'hF;
    rx = 32'h0;
    ok = 1'b1;
    cs_n_out = 1'b0;
    hdrv = 1'b1;
    for (int i = 0; i < ntx; i++) begin
      hval = tx[63:60] >> (4 - wtx);
      tx = tx << wtx;
      #3 sclk_out = 1'b1;
      if (dev_oe_n_in !== 4'hF) ok = 1'b0;
      #1 hdrv = (i < ntx - 1);
      #2 sclk_out = 1'b0;
    end
    for (int i = 0; i < nrx; i++) begin
      #3 sclk_out = 1'b1;
      rx = (rx << wrx) | 32'((wrx == 1) ? {3'h0, line_out[1]} : (line_out & need));
      if ((~dev_oe_n_in & need) !== need) ok = 1'b0;
      #3 sclk_out = 1'b0;
    end
    #3 cs_n_out = 1'b1;
    #40;
  endtask
endmodule // sfr_host_model

// File: test/tb_sfr_flash.sv
// self-checking bench for the serial flash sequencer
// assumes the host model drives the link and the checker is bound below
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
module tb_sfr_flash;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_in = 1'b0;
  logic reset_in = 1'b0;
  logic qe = 1'b0;
  logic qmode = 1'b0;
  logic [2:0] prot = 3'h0;
  logic [1:0] rparam = 2'h0;
  logic rload = 1'b0;
  logic sclk, cs_n, busy, write_enable_latch, suspended_flag, ok;
  logic [3:0] line, val, oe_n;
  logic [31:0] rx;
  logic [7:0] eop [6] = '{8'h20, 8'h52, 8'hD8, 8'h44, 8'hC7, 8'h60};
  logic [7:0] pop [3] = '{8'h02, 8'h32, 8'h42};
  int err_count = 0;
  int n_tests = 0;
  always #2.5 clock_in = ~clock_in;
  sfr_host_model host (.dev_val_in(val), .dev_oe_n_in(oe_n), .sclk_out(sclk), .cs_n_out(cs_n),
    .line_out(line));
  sfr_flash #(.AW(8), .T_OP_NS(2000), .T_SUS_NS(20)) uut (.clock_in(clock_in),
    .reset_in(reset_in), .sclk_in(sclk), .chip_select_n_in(cs_n), .io_line_0_in(line[0]),
    .io_line_1_in(line[1]), .io_line_2_in(line[2]), .io_line_3_in(line[3]),
    .io_line_0_out(val[0]), .io_line_1_out(val[1]), .io_line_2_out(val[2]),
    .io_line_3_out(val[3]), .io_line_0_oe_n_out(oe_n[0]), .io_line_1_oe_n_out(oe_n[1]),
    .io_line_2_oe_n_out(oe_n[2]), .io_line_3_oe_n_out(oe_n[3]), .quad_lines_enable_in(qe),
    .quad_command_mode_in(qmode), .protect_field_bit2_in(prot[2]),
    .protect_field_bit1_in(prot[1]), .protect_field_bit0_in(prot[0]),
    .read_param_in(rparam), .read_param_load_in(rload), .busy_out(busy),
    .write_enable_latch_out(write_enable_latch), .suspended_flag_out(suspended_flag));
  task summarize();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task wait_busy(input logic v);
    int k;
    k = 0;
    while (busy !== v && k < 1000) begin
      @(negedge clock_in);
      k++;
    end
    if (k == 1000) begin
      err_count++;
      $display("BAD busy wait expected %h seen %h", v, busy);
      summarize();
    end
  endtask
  task cmd(input logic [63:0] tx, input int ntx);
    @(negedge clock_in);
    host.frame(tx, ntx, 1, 0, 1, rx, ok);
  endtask
  // erased array reads back all ones on every driven lane
  task rd(input string nm, input logic [63:0] tx, input int ntx, input int wtx, input int nrx,
          input int wrx, input logic eok);
    @(negedge clock_in);
    host.frame(tx, ntx, wtx, nrx, wrx, rx, ok);
    `CHK(nm, eok, ok)
    if (eok)
      `CHK(nm, 32'hFFFFFFFF >> (32 - nrx * wrx), rx)
  endtask
  initial begin
    // a real rising edge is needed to clear the link-side flops
    #1 reset_in = 1'b1;
    repeat (3) @(negedge clock_in);
    reset_in = 1'b0;
    repeat (2) @(negedge clock_in);
    `CHK("flags", 3'h0, {busy, write_enable_latch, suspended_flag})
    cmd({8'h7A, 56'h0}, 8);
    `CHK("idle resume", 2'h0, {busy, suspended_flag})
    cmd({8'h75, 56'h0}, 8);
    `CHK("idle suspend", 1'b0, suspended_flag)
    $display("idle test done");
    @(negedge clock_in) prot = 3'h4;
    cmd({8'h06, 56'h0}, 8);
    cmd({8'hC7, 56'h0}, 8);
    `CHK("protected erase", 2'h1, {busy, write_enable_latch})
    @(negedge clock_in) prot = 3'h0;
    cmd({8'h60, 56'h0}, 9);
    `CHK("long frame erase", 1'b0, busy)
    cmd({8'h60, 56'h0}, 8);
    `CHK("erase busy", 1'b1, busy)
    cmd({8'h75, 56'h0}, 8);
    `CHK("erase suspend", 1'b0, suspended_flag)
    rd("busy read", {8'h03, 56'h0}, 32, 1, 8, 1, 1'b0);
    wait_busy(1'b0);
    `CHK("latch after erase", 1'b0, write_enable_latch)
    $display("array erase test done");
    rd("plain read", {8'h03, 24'h0000FF, 32'h0}, 32, 1, 16, 1, 1'b1);
    rd("fast read", {8'h0B, 24'h000040, 32'h0}, 40, 1, 8, 1, 1'b1);
    rd("dual read", {8'h3B, 24'h000041, 32'h0}, 40, 1, 8, 2, 1'b1);
    rd("quad off", {8'h6B, 24'h000042, 32'h0}, 40, 1, 8, 4, 1'b0);
    @(negedge clock_in) qe = 1'b1;
    cmd({8'h03, 56'h0}, 8);
    rd("quad read", {8'h6B, 24'h000043, 32'h0}, 40, 1, 8, 4, 1'b1);
    $display("read test done");
    cmd({8'h06, 56'h0}, 8);
    cmd({8'h20, 24'h001000, 32'h0}, 32);
    cmd({8'h75, 56'h0}, 8);
    `CHK("erase suspended", 1'b1, suspended_flag)
    wait_busy(1'b0);
    cmd({8'h02, 24'h001010, 8'hA5, 24'h0}, 40);
    `CHK("suspended sector", 1'b0, busy)
    foreach (eop[i]) begin
      cmd({8'h06, 56'h0}, 8);
      cmd({eop[i], 24'h005000, 32'h0}, (i < 4) ? 32 : 8);
      `CHK("erase in suspend", 1'b0, busy)
    end
    cmd({8'h7A, 56'h0}, 8);
    `CHK("resume", 2'h2, {busy, suspended_flag})
    wait_busy(1'b0);
    $display("erase suspend test done");
    cmd({8'h06, 56'h0}, 8);
    cmd({8'h02, 24'h002000, 8'hA5, 24'h0}, 40);
    cmd({8'h75, 56'h0}, 8);
    `CHK("program suspended", 1'b1, suspended_flag)
    wait_busy(1'b0);
    foreach (pop[i]) begin
      cmd({8'h06, 56'h0}, 8);
      cmd({pop[i], 24'h007000, 8'hA5, 24'h0}, 40);
      `CHK("program in suspend", 1'b0, busy)
    end
    cmd({8'h7A, 56'h0}, 8);
    wait_busy(1'b0);
    `CHK("program resumed", 1'b0, suspended_flag)
    $display("program suspend test done");
    @(negedge clock_in) qmode = 1'b1;
    @(negedge clock_in);
    host.frame({8'h03, 56'h0}, 2, 4, 0, 1, rx, ok);
    for (int c = 0; c < 4; c++) begin
      @(negedge clock_in) rparam = 2'(c);
      rload = (c != 0);
      @(negedge clock_in) rload = 1'b0;
      rd("quad mode read", {8'h0B, 24'h000010, 32'h0}, (c < 2) ? 12 : 2 * c + 10, 4, 2, 4,
         1'b1);
    end
    $display("quad mode test done");
    summarize();
  end
endmodule // tb_sfr_flash
bind sfr_flash sfr_flash_assertions #(.T_SUS_NS(T_SUS_NS)) u_chk (.clock_in(clock_in),
  .reset_in(reset_in), .sclk_in(sclk_in), .chip_select_n_in(chip_select_n_in),
  .io_line_0_oe_n_out(io_line_0_oe_n_out), .io_line_1_oe_n_out(io_line_1_oe_n_out),
  .io_line_3_oe_n_out(io_line_3_oe_n_out), .quad_lines_enable_in(quad_lines_enable_in),
  .quad_command_mode_in(quad_command_mode_in), .busy_out(busy_out),
  .write_enable_latch_out(write_enable_latch_out), .suspended_flag_out(suspended_flag_out));
